// File: core/acs_pkg.sv
package acs_pkg;

  // Geometry
  localparam int          NUM_CONV       = 2;
  localparam int          ADDR_W         = 13;
  localparam int          SYNC_STAGES    = 2;
  localparam logic [3:0]  HDR_LAST_BIT   = 4'hf;
  localparam logic [2:0]  BYTE_LAST_BIT  = 3'h7;

  // Register offsets
  localparam logic [12:0] ADDR_PORT_CFG  = 13'h0000;
  localparam logic [12:0] ADDR_BURST_END = 13'h0002;
  localparam logic [12:0] ADDR_DIE_ID    = 13'h0008;
  localparam logic [12:0] ADDR_DIE_REV   = 13'h0009;
  localparam logic [12:0] ADDR_CONV_SEL  = 13'h0010;
  localparam logic [12:0] ADDR_OFS_CRS   = 13'h0020;
  localparam logic [12:0] ADDR_OFS_FINE  = 13'h0021;
  localparam logic [12:0] ADDR_GAIN_CRS  = 13'h0022;
  localparam logic [12:0] ADDR_GAIN_MED  = 13'h0023;
  localparam logic [12:0] ADDR_GAIN_FINE = 13'h0024;
  localparam logic [12:0] ADDR_PWR_SEL   = 13'h0025;
  localparam logic [12:0] ADDR_STEP      = 13'h0001;

  // Header field positions
  localparam int          HDR_READ_BIT   = 15;
  localparam int          HDR_CNT_HI     = 14;
  localparam int          HDR_CNT_LO     = 13;
  localparam logic [1:0]  CNT_BURST      = 2'h3;

  // Port configuration fields
  localparam int          CFG_FOUR_WIRE  = 7;
  localparam int          CFG_LSB_FIRST  = 6;
  localparam int          CFG_SOFT_RST   = 5;

  // Reset values and codes
  localparam logic [7:0]  PORT_CFG_RST   = 8'h18;
  localparam logic [7:0]  BURST_END_RST  = 8'h00;
  localparam logic [7:0]  CONV_SEL_RST   = 8'h00;
  localparam logic [7:0]  TRIM_MID       = 8'h80;
  localparam logic [3:0]  GAIN_CRS_RST   = 4'h0;
  localparam logic [2:0]  PWR_PIN_CTRL   = 3'h0;
  localparam logic [7:0]  ERR_BYTE       = 8'had;
  localparam logic [7:0]  UNMAPPED_BYTE  = 8'h00;
  localparam logic [7:0]  SEL_CONV0      = 8'h01;
  localparam logic [7:0]  SEL_CONV1      = 8'h02;

  // Identification, values are arbitrary
  localparam logic [7:0]  DIE_ID_VAL     = 8'h5a;
  localparam logic [7:0]  DIE_REV_VAL    = 8'h01;

  typedef enum logic {ACS_ORD_MSB, ACS_ORD_LSB} acs_order_t;

  typedef struct packed {
    logic [7:0] offset_coarse;
    logic [7:0] offset_fine;
    logic [3:0] gain_coarse;
    logic [7:0] gain_medium;
    logic [7:0] gain_fine;
  } acs_trim_t;

  typedef struct packed {
    acs_trim_t  trim;
    logic [2:0] power_mode;
  } acs_conv_t;

  typedef struct packed {
    logic       port_select_n;
    logic       sclk;
    logic       sdio_in;
    logic [2:0] power_state_pin;
  } acs_pins_t;

  typedef struct packed {
    logic sdio_out;
    logic sdio_oe;
    logic serial_data_out_pin;
    logic serial_data_out_oe;
  } acs_drive_t;

endpackage

// File: core/acs_spi_slave.sv
`timescale 1ns/1ps
// Operation
// R1 - Three-wire default; config bit 7 enables output
// R2 - Pure half-duplex slave, master clocks everything
// R3 - Four-wire output driven even when unselected
// R4 - Header starts first rising edge after select
// R5 - Config bit 6 selects LSB-first order
// R6 - Address up when MSB-first, down otherwise
// R7 - Header: read flag, count code, 13-bit address
// R8 - Codes give 1-3 bytes, 11 is burst
// R9 - Short transfers pause at byte boundaries
// R10 - Long transfers abort on late select rise
// R11 - Config bit 5 restores register defaults
// R12 - Master writes bit 4 high, mirrored nibble
// R13 - Burst ends on select rise or end address
// R14 - Readable die identifier and revision registers
// R15 - Converter select resets zero, one converter only
// R16 - Indexed read without valid select returns AD
// R17 - Offset trims 8-bit, 0x80 is zero
// R18 - Trims start at calibration result
// R19 - Coarse gain four weighted bits
// R20 - Medium and fine gain 8-bit, 0x80 neutral
// R21 - Power field overrides pin, soft reset keeps
// R22 - Master writes select/mode pairs per converter
// R23 - Master limits serial rate, keeps clock running
// R24 - Data pin driven only during read data
module acs_spi_slave (
  // Clock and reset
  input  wire logic                                   clk_sys,
  input  wire logic                                   rst_n,
  // Serial pins and power pin
  input  wire acs_pkg::acs_pins_t                     pins,
  output acs_pkg::acs_drive_t                         drive,
  // Calibration results from the core
  input  wire logic                                   cal_load,
  input  wire acs_pkg::acs_trim_t [acs_pkg::NUM_CONV-1:0] cal_trim,
  // Settings to the converter cores
  output acs_pkg::acs_conv_t [acs_pkg::NUM_CONV-1:0]  conv_ctrl,
  output logic                                        four_wire_enable
);
  import acs_pkg::*;

  typedef enum logic [1:0] {ST_HDR, ST_DATA, ST_DONE} acs_state_t;

  function automatic logic idx_ok(input logic [7:0] sel);
    idx_ok = (sel == SEL_CONV0) || (sel == SEL_CONV1);
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] cur,
                                          input logic       bit_in,
                                          input logic       lsb);
    shift_in = lsb ? {bit_in, cur[7:1]} : {cur[6:0], bit_in};
  endfunction

  acs_pins_t                  sync1_r;
  acs_pins_t                  sync2_r;
  logic                       cs_d_r;
  logic                       sclk_d_r;
  acs_state_t                 state_r;
  logic [15:0]                hdr_r;
  logic [15:0]                hdr_nxt;
  logic [3:0]                 hdr_cnt_r;
  logic [2:0]                 bit_idx_r;
  logic [7:0]                 rx_r;
  logic [7:0]                 rx_nxt;
  logic [7:0]                 tx_r;
  logic                       sdo_bit_r;
  logic                       is_read_r;
  logic                       burst_r;
  logic                       first_done_r;
  logic [1:0]                 left_r;
  logic [ADDR_W-1:0]          addr_r;
  logic [ADDR_W-1:0]          addr_nxt;
  logic [7:0]                 port_cfg_r;
  logic [7:0]                 burst_end_r;
  logic [7:0]                 conv_sel_r;
  acs_trim_t                  cal_r [NUM_CONV];
  acs_conv_t                  conv_r [NUM_CONV];
  logic [7:0]                 rd_byte;
  logic                       cs_n;
  logic                       sclk_rise;
  logic                       sclk_fall;
  logic                       cs_rise;
  logic                       wr_fire;
  logic                       soft_rst;
  logic                       sel_conv;
  acs_order_t                 order;

  // Two stages before anything looks at a pin
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // Idle select level, so no false select edge follows reset
      sync1_r <= '{1'b1, 1'b0, 1'b0, 3'h0};
      sync2_r <= '{1'b1, 1'b0, 1'b0, 3'h0};
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  // Select and clock come through equal delays, keeping their order
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cs_d_r   <= 1'b1;
      sclk_d_r <= 1'b0;
    end else begin
      cs_d_r   <= sync2_r.port_select_n;
      sclk_d_r <= sync2_r.sclk;
    end
  end

  assign cs_n      = sync2_r.port_select_n;
  // Only edges while selected count; the slave never makes a clock [R2]
  assign sclk_rise = !cs_n && sync2_r.sclk && !sclk_d_r; // [R4]
  assign sclk_fall = !cs_n && !sync2_r.sclk && sclk_d_r;
  assign cs_rise   = cs_n && !cs_d_r;

  assign order   = port_cfg_r[CFG_LSB_FIRST] ? ACS_ORD_LSB : ACS_ORD_MSB;
  // Whole-word shift keeps field positions identical in either order [R5]
  assign hdr_nxt = (order == ACS_ORD_LSB) ?
                   {sync2_r.sdio_in, hdr_r[15:1]} :
                   {hdr_r[14:0], sync2_r.sdio_in};
  assign rx_nxt  = shift_in(rx_r, sync2_r.sdio_in,
                            order == ACS_ORD_LSB); // [R5]
  assign addr_nxt = (order == ACS_ORD_LSB) ? addr_r - ADDR_STEP :
                                             addr_r + ADDR_STEP; // [R6]

  assign wr_fire  = sclk_rise && (state_r == ST_DATA) &&
                    (bit_idx_r == BYTE_LAST_BIT) && !is_read_r;
  assign soft_rst = wr_fire && (addr_r == ADDR_PORT_CFG) &&
                    rx_nxt[CFG_SOFT_RST]; // [R11]
  assign sel_conv = conv_sel_r[1];

  // Protocol sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r      <= ST_HDR;
      hdr_r        <= '0;
      hdr_cnt_r    <= '0;
      bit_idx_r    <= '0;
      rx_r         <= '0;
      is_read_r    <= 1'b0;
      burst_r      <= 1'b0;
      first_done_r <= 1'b0;
      left_r       <= '0;
      addr_r       <= '0;
    end else if (cs_rise) begin
      case (state_r)
        ST_HDR: begin
          // Mid-byte release cannot be resumed
          if (hdr_cnt_r[2:0] != 3'h0) begin
            hdr_cnt_r <= '0;
          end
        end
        ST_DATA: begin
          if (bit_idx_r != 3'h0) begin
            state_r   <= ST_HDR;
            hdr_cnt_r <= '0;
            bit_idx_r <= '0;
          end else if (burst_r && first_done_r) begin
            state_r   <= ST_HDR; // [R10] [R13]
            hdr_cnt_r <= '0;
          end
          // Else a boundary pause; state held until select returns [R9]
        end
        ST_DONE: begin
          state_r   <= ST_HDR;
          hdr_cnt_r <= '0;
        end
        default: begin
          state_r   <= ST_HDR;
          hdr_cnt_r <= '0;
        end
      endcase
    end else if (sclk_rise) begin
      case (state_r)
        ST_HDR: begin
          hdr_r     <= hdr_nxt;
          hdr_cnt_r <= hdr_cnt_r + 4'h1;
          if (hdr_cnt_r == HDR_LAST_BIT) begin
            state_r      <= ST_DATA;
            is_read_r    <= hdr_nxt[HDR_READ_BIT]; // [R7]
            left_r       <= hdr_nxt[HDR_CNT_HI:HDR_CNT_LO]; // [R8]
            burst_r      <= hdr_nxt[HDR_CNT_HI:HDR_CNT_LO] == CNT_BURST;
            addr_r       <= hdr_nxt[ADDR_W-1:0]; // [R7]
            bit_idx_r    <= '0;
            first_done_r <= 1'b0;
          end
        end
        ST_DATA: begin
          rx_r      <= rx_nxt;
          bit_idx_r <= bit_idx_r + 3'h1;
          if (bit_idx_r == BYTE_LAST_BIT) begin
            first_done_r <= 1'b1;
            addr_r       <= addr_nxt; // [R6]
            if (burst_r) begin
              if (addr_r == {5'h00, burst_end_r}) begin
                state_r <= ST_DONE; // [R13]
              end
            end else if (left_r == 2'h0) begin
              state_r <= ST_DONE; // [R8]
            end else begin
              left_r <= left_r - 2'h1;
            end
          end
        end
        ST_DONE: begin
          // Surplus clocks are ignored until select rises
          hdr_cnt_r <= '0;
        end
        default: begin
          state_r <= ST_HDR;
        end
      endcase
    end
  end

  // Read data mux
  always_comb begin
    rd_byte = UNMAPPED_BYTE;
    case (addr_r)
      ADDR_PORT_CFG:  rd_byte = port_cfg_r;
      ADDR_BURST_END: rd_byte = burst_end_r;
      ADDR_DIE_ID:    rd_byte = DIE_ID_VAL; // [R14]
      ADDR_DIE_REV:   rd_byte = DIE_REV_VAL; // [R14]
      ADDR_CONV_SEL:  rd_byte = conv_sel_r;
      ADDR_OFS_CRS: begin
        rd_byte = idx_ok(conv_sel_r) ?
                  conv_r[sel_conv].trim.offset_coarse : ERR_BYTE; // [R16]
      end
      ADDR_OFS_FINE: begin
        rd_byte = idx_ok(conv_sel_r) ?
                  conv_r[sel_conv].trim.offset_fine : ERR_BYTE; // [R16]
      end
      ADDR_GAIN_CRS: begin
        rd_byte = idx_ok(conv_sel_r) ?
                  {4'h0, conv_r[sel_conv].trim.gain_coarse} :
                  ERR_BYTE; // [R16]
      end
      ADDR_GAIN_MED: begin
        rd_byte = idx_ok(conv_sel_r) ?
                  conv_r[sel_conv].trim.gain_medium : ERR_BYTE; // [R16]
      end
      ADDR_GAIN_FINE: begin
        rd_byte = idx_ok(conv_sel_r) ?
                  conv_r[sel_conv].trim.gain_fine : ERR_BYTE; // [R16]
      end
      ADDR_PWR_SEL: begin
        rd_byte = idx_ok(conv_sel_r) ?
                  {5'h00, conv_r[sel_conv].power_mode} : ERR_BYTE; // [R16]
      end
      default: rd_byte = UNMAPPED_BYTE;
    endcase
  end

  // Read shifter; bits change on falling edges, master samples on rising
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_r      <= '0;
      sdo_bit_r <= 1'b0;
    end else if (sclk_fall && (state_r == ST_DATA) && is_read_r) begin
      if (bit_idx_r == 3'h0) begin
        sdo_bit_r <= (order == ACS_ORD_LSB) ? rd_byte[0] : rd_byte[7];
        tx_r      <= (order == ACS_ORD_LSB) ? {1'b0, rd_byte[7:1]} :
                                              {rd_byte[6:0], 1'b0}; // [R5]
      end else begin
        sdo_bit_r <= (order == ACS_ORD_LSB) ? tx_r[0] : tx_r[7];
        tx_r      <= (order == ACS_ORD_LSB) ? {1'b0, tx_r[7:1]} :
                                              {tx_r[6:0], 1'b0};
      end
    end
  end

  // Port configuration; bit 4 and the mirror stored as written [R12]
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      port_cfg_r <= PORT_CFG_RST;
    end else if (soft_rst) begin
      port_cfg_r <= PORT_CFG_RST; // [R11]
    end else if (wr_fire && (addr_r == ADDR_PORT_CFG)) begin
      port_cfg_r <= rx_nxt;
    end
  end

  // Burst end address
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      burst_end_r <= BURST_END_RST;
    end else if (soft_rst) begin
      burst_end_r <= BURST_END_RST; // [R11]
    end else if (wr_fire && (addr_r == ADDR_BURST_END)) begin
      burst_end_r <= rx_nxt; // [R13]
    end
  end

  // Converter select; master is trusted to pick only one [R22]
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      conv_sel_r <= CONV_SEL_RST; // [R15]
    end else if (soft_rst) begin
      conv_sel_r <= CONV_SEL_RST; // [R11] [R15]
    end else if (wr_fire && (addr_r == ADDR_CONV_SEL)) begin
      conv_sel_r <= rx_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CONV; g++) begin : g_conv
      logic hit;
      assign hit = wr_fire && idx_ok(conv_sel_r) &&
                   (sel_conv == 1'(g)); // [R15]

      // Calibration snapshot serves as the soft-reset default
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          cal_r[g] <= {TRIM_MID, TRIM_MID, GAIN_CRS_RST,
                       TRIM_MID, TRIM_MID};
        end else if (cal_load) begin
          cal_r[g] <= cal_trim[g]; // [R18]
        end
      end

      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          conv_r[g].trim       <= {TRIM_MID, TRIM_MID, GAIN_CRS_RST,
                                   TRIM_MID, TRIM_MID}; // [R17] [R20]
          conv_r[g].power_mode <= PWR_PIN_CTRL;
        end else begin
          if (cal_load) begin
            conv_r[g].trim <= cal_trim[g]; // [R18]
          end else if (soft_rst) begin
            conv_r[g].trim <= cal_r[g]; // [R11] [R18]
          end else if (hit) begin
            case (addr_r)
              ADDR_OFS_CRS:   conv_r[g].trim.offset_coarse <= rx_nxt; // [R17]
              ADDR_OFS_FINE:  conv_r[g].trim.offset_fine   <= rx_nxt; // [R17]
              ADDR_GAIN_CRS:
                conv_r[g].trim.gain_coarse <= rx_nxt[3:0]; // [R19]
              ADDR_GAIN_MED:  conv_r[g].trim.gain_medium   <= rx_nxt; // [R20]
              ADDR_GAIN_FINE: conv_r[g].trim.gain_fine     <= rx_nxt; // [R20]
              default:        conv_r[g].trim <= conv_r[g].trim;
            endcase
          end
          // Power field ignores soft reset
          if (hit && (addr_r == ADDR_PWR_SEL)) begin
            conv_r[g].power_mode <= rx_nxt[2:0]; // [R21]
          end
        end
      end
    end
  endgenerate

  // Registered settings to the core; nonzero field beats the pin
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      conv_ctrl <= '0;
    end else begin
      for (int i = 0; i < NUM_CONV; i++) begin
        conv_ctrl[i].trim       <= conv_r[i].trim;
        conv_ctrl[i].power_mode <=
          (conv_r[i].power_mode != PWR_PIN_CTRL) ?
          conv_r[i].power_mode : sync2_r.power_state_pin; // [R21]
      end
    end
  end

  // Pin drivers
  assign four_wire_enable = port_cfg_r[CFG_FOUR_WIRE]; // [R1]
  always_comb begin
    drive.sdio_out            = sdo_bit_r;
    // Data pin turns only for read data, and only without four-wire [R24]
    drive.sdio_oe             = !four_wire_enable && !cs_n &&
                                (state_r == ST_DATA) && is_read_r; // [R1]
    drive.serial_data_out_pin = sdo_bit_r;
    // Always driven in four-wire, even unselected; no bus sharing [R3]
    drive.serial_data_out_oe  = four_wire_enable; // [R1] [R3]
  end

endmodule // acs_spi_slave

// File: testbench/acs_spi_master_model.sv
`timescale 1ns/1ps
module acs_spi_master_model (
  // Serial wires
  output logic      port_select_n,
  output logic      sclk,
  output logic      sdio_m,
  input  wire logic sdio_w,
  input  wire logic sdo_w
);
  bit lsb;
  bit four;
  initial begin
    port_select_n = 1'b1;
    sclk = 1'b0; // Parked low between frames
    sdio_m = 1'b0;
  end

  // 80 ns period, well inside the slowest read rate
  task automatic shift(input logic [15:0] v, input int nb, input bit rd,
                       output logic [15:0] r);
    int k;
    r = '0;
    for (int i = 0; i < nb; i++) begin
      k = lsb ? i : nb - 1 - i;
      sdio_m = rd ? ~sdio_m : v[k]; // Released line toggles
      #40;
      r[k] = four ? sdo_w : sdio_w;
      sclk = 1'b1;
      #40 sclk = 1'b0;
    end
  endtask

  // Header then nb bytes; select pauses before byte pb
  task automatic xfer(input logic [15:0] hdr, input int nb, input int pb,
                      input logic [31:0] wd, output logic [31:0] rdat);
    logic [15:0] t;
    rdat = '0;
    port_select_n = 1'b0; // One slave, never concurrent reads
    #40;
    shift(hdr, 16, 1'b0, t);
    for (int b = 0; b < nb; b++) begin
      if (b == pb) begin
        port_select_n = 1'b1;
        #400 port_select_n = 1'b0;
        #40;
      end
      shift({8'h00, wd[8*b+:8]}, 8, hdr[15], t);
      rdat[8*b+:8] = t[7:0];
    end
    #40 port_select_n = 1'b1; // Ends a burst
    #400;
  endtask
endmodule // acs_spi_master_model

// File: testbench/acs_spi_slave_sva.sv
`timescale 1ns/1ps
module acs_spi_slave_chk (
  // Clock and reset
  input wire logic                                    clk_sys,
  input wire logic                                    rst_n,
  // Serial side
  input wire acs_pkg::acs_pins_t                      pins,
  input wire acs_pkg::acs_drive_t                     drive,
  // Core side
  input wire logic                                    cal_load,
  input wire acs_pkg::acs_trim_t [acs_pkg::NUM_CONV-1:0] cal_trim,
  input wire acs_pkg::acs_conv_t [acs_pkg::NUM_CONV-1:0] conv_ctrl,
  input wire logic                                    four_wire_enable
);
  import acs_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Margin covers the two-stage select synchroniser
  sequence s_idle;
    pins.port_select_n [*6];
  endsequence
  sequence s_clk_high;
    (!pins.port_select_n && pins.sclk) [*3];
  endsequence

  AST_OE_IDLE: assert property (s_idle |-> !drive.sdio_oe)
    else $error("data pin driven while deselected");
  AST_OE_THREE_WIRE: assert property (drive.sdio_oe |-> !four_wire_enable)
    else $error("data pin driven in four-wire mode");
  AST_SDO_ENABLE: assert property (drive.serial_data_out_oe == four_wire_enable)
    else $error("output pin enable does not follow four-wire bit");
  AST_SDO_VALUE: assert property (drive.serial_data_out_pin == drive.sdio_out)
    else $error("two output pins disagree");
  AST_OE_ROSE: assert property ($rose(drive.sdio_oe) |-> !$past(pins.port_select_n, 2))
    else $error("data pin enabled without selection");
  AST_OUT_HOLD: assert property (s_clk_high |-> $stable(drive.sdio_out))
    else $error("read bit moved without a clock fall");
  AST_TRIM_MID: assert property ($rose(rst_n) |=> conv_ctrl[0].trim.offset_coarse == TRIM_MID && conv_ctrl[0].trim.gain_coarse == GAIN_CRS_RST)
    else $error("trim not neutral after reset");
  AST_CAL_LOAD: assert property (cal_load |-> ##2 conv_ctrl[1].trim == $past(cal_trim[1], 2))
    else $error("calibration result not loaded");
  AST_FOUR_CHANGE: assert property ($changed(four_wire_enable) |-> !$past(pins.port_select_n, 3))
    else $error("four-wire bit changed outside a transfer");
endmodule // acs_spi_slave_chk

bind acs_spi_slave acs_spi_slave_chk i_acs_spi_slave_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .pins(pins), .drive(drive),
  .cal_load(cal_load), .cal_trim(cal_trim), .conv_ctrl(conv_ctrl),
  .four_wire_enable(four_wire_enable)
);

// File: testbench/adc_spi_config_slave_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch at %0t: got %h want %h", $time, a, e); end end
module adc_spi_config_slave_test;
  import acs_pkg::*;
  localparam acs_trim_t CAL = '{8'h70, 8'h90, 4'h5, 8'h81, 8'h7f};
  logic                     clk_sys = 1'b0;
  logic                     rst_n = 1'b0;
  logic                     cal_load = 1'b0;
  logic [2:0]               pwr_pin = 3'h1;
  acs_trim_t [NUM_CONV-1:0] cal_trim;
  acs_pins_t                pins;
  acs_drive_t               drive;
  acs_conv_t [NUM_CONV-1:0] conv_ctrl;
  logic                     four_wire_enable;
  logic                     csn;
  logic                     sclk;
  logic                     sdio_m;
  logic                     sdio_w;
  logic [31:0]              rd;
  int                       bad_count = 0;
  int                       cmp_count = 0;

  always #4 clk_sys = ~clk_sys;
  assign sdio_w = drive.sdio_oe ? drive.sdio_out : sdio_m;
  assign pins = '{csn, sclk, sdio_w, pwr_pin};

  acs_spi_slave i_acs_spi_slave (
    .clk_sys(clk_sys), .rst_n(rst_n), .pins(pins), .drive(drive),
    .cal_load(cal_load), .cal_trim(cal_trim), .conv_ctrl(conv_ctrl),
    .four_wire_enable(four_wire_enable)
  );
  // Output pin has a pull-up when not driven
  acs_spi_master_model i_master (
    .port_select_n(csn), .sclk(sclk), .sdio_m(sdio_m), .sdio_w(sdio_w),
    .sdo_w(drive.serial_data_out_oe ? drive.serial_data_out_pin : 1'b1)
  );

  task automatic clk_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    i_master.xfer({3'b000, a}, 1, -1, {24'h0, d}, rd);
  endtask
  task automatic rdb(input logic [12:0] a, input logic [7:0] e);
    i_master.xfer({3'b100, a}, 1, -1, 32'h0, rd);
    `CHK(rd[7:0], e)
  endtask

  task automatic t_reset;
    `CHK(drive.sdio_oe, 1'b0)
    `CHK(four_wire_enable, 1'b0)
    wr(ADDR_DIE_ID, 8'hff);
    i_master.xfer({3'b110, ADDR_DIE_ID}, 3, -1, 32'h0, rd);
    `CHK(rd[23:0], {UNMAPPED_BYTE, DIE_REV_VAL, DIE_ID_VAL})
    rdb(ADDR_PORT_CFG, PORT_CFG_RST);
    rdb(ADDR_CONV_SEL, CONV_SEL_RST);
    rdb(ADDR_OFS_CRS, ERR_BYTE);
  endtask

  task automatic t_trim;
    @(negedge clk_sys) cal_load = 1'b1;
    @(negedge clk_sys) cal_load = 1'b0;
    clk_n(2);
    `CHK(conv_ctrl[1].trim, CAL)
    wr(ADDR_CONV_SEL, SEL_CONV0);
    i_master.xfer({1'b1, CNT_BURST, ADDR_OFS_CRS}, 4, -1, 32'h0, rd);
    `CHK(rd, 32'h81_05_90_70)
    i_master.xfer({1'b0, CNT_BURST, ADDR_OFS_CRS}, 4, 0, 32'h80_0c_ff_00, rd);
    clk_n(6);
    `CHK(conv_ctrl[0].trim, acs_trim_t'(36'h00_ff_c_80_7f))
    `CHK(conv_ctrl[1].trim, CAL)
    i_master.xfer({3'b001, ADDR_GAIN_MED}, 2, 1, 32'h0000_3cc3, rd);
    clk_n(6);
    `CHK(conv_ctrl[0].trim[15:0], 16'hc33c)
  endtask

  task automatic t_burst_end;
    wr(ADDR_BURST_END, 8'h21);
    i_master.xfer({1'b0, CNT_BURST, ADDR_OFS_CRS}, 3, -1, 32'h33_22_11, rd);
    clk_n(6);
    `CHK(conv_ctrl[0].trim[35:16], 20'h11_22_c)
  endtask

  task automatic t_power;
    logic [2:0] m;
    @(negedge clk_sys) pwr_pin = 3'h4;
    clk_n(6);
    `CHK(conv_ctrl[1].power_mode, 3'h4)
    for (int i = 1; i <= 2; i++) begin
      m = 3'(i);
      wr(ADDR_CONV_SEL, SEL_CONV0);
      wr(ADDR_PWR_SEL, {5'h0, m});
      wr(ADDR_CONV_SEL, SEL_CONV1);
      wr(ADDR_PWR_SEL, {5'h0, m});
      clk_n(6);
      `CHK({conv_ctrl[1].power_mode, conv_ctrl[0].power_mode}, {m, m})
      rdb(ADDR_PWR_SEL, {5'h0, m});
    end
  endtask

  task automatic t_order_soft_reset;
    wr(ADDR_PORT_CFG, 8'h5a); // Mirrored nibble
    i_master.lsb = 1'b1;
    i_master.xfer({3'b101, ADDR_DIE_REV}, 2, -1, 32'h0, rd);
    `CHK(rd[15:0], {DIE_ID_VAL, DIE_REV_VAL})
    wr(ADDR_PORT_CFG, 8'h3c);
    i_master.lsb = 1'b0;
    clk_n(6);
    `CHK(conv_ctrl[0].trim, CAL)
    `CHK(conv_ctrl[0].power_mode, 3'h2)
    rdb(ADDR_PORT_CFG, PORT_CFG_RST);
    rdb(ADDR_BURST_END, BURST_END_RST);
  endtask

  task automatic t_four_wire;
    wr(ADDR_PORT_CFG, 8'h99);
    i_master.four = 1'b1;
    clk_n(6);
    `CHK(drive.serial_data_out_oe, 1'b1)
    `CHK(four_wire_enable, 1'b1)
    rdb(ADDR_DIE_ID, DIE_ID_VAL);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    cal_trim = {CAL, CAL};
    clk_n(12);
    rst_n = 1'b1;
    clk_n(4);
    t_reset();
    t_trim();
    t_burst_end();
    t_power();
    t_order_soft_reset();
    t_four_wire();
    end_of_test();
  end

  // Run needs about 76 us; allow well beyond
  initial begin
    #400000;
    bad_count++;
    end_of_test();
  end
endmodule // adc_spi_config_slave_test
